// [abs_encoder_origin_offset_tb.sv]
`timescale 1ns/1ps
`include "aeo_map.vh"
module abs_encoder_origin_offset_tb;
    logic ref_clk = 1'h0;
    logic reset_n = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic save_pending_nv = 1'h0;
    logic [31:0] tgt = 32'h0;
    logic [31:0] reg_rdata, fb_pos, flash_data, rv;
    logic fb_valid, flash_wr, flash_done, save_pending_set, irq;
    logic [2:0] flash_slot;
    logic [3:0] unit_err;
    int fail_count = 0;
    int total_checks = 0;
    int saves = 0;
    int i;
    initial forever #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (flash_wr === 1'h1) saves++;
    aeo_origin uut (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .fb_pos, .fb_valid, .flash_wr, .flash_slot,
        .flash_data, .flash_done, .save_pending_nv, .save_pending_set,
        .irq, .unit_err);
    aeo_drive_model drv (.ref_clk, .tgt_pos(tgt), .fb_pos, .fb_valid,
        .flash_wr, .flash_done);
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        #1;
        rv = reg_rdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Busy drops requests, so let each save finish before going on
    // The save pulse may already be past, so the edge counter is used
    task automatic wait_save(input logic [31:0] e, input logic [2:0] s);
        for (i = 0; i < 40 && saves == 0; i++)
            @(posedge ref_clk);
        if (saves == 0) begin
            fail_count++;
            $display("unexpected save exp 1 got 0");
            give_verdict();
        end
        chk("flash data", e, flash_data);
        chk("flash slot", {29'h0, s}, {29'h0, flash_slot});
        saves = 0;
        repeat (20) @(posedge ref_clk);
    endtask
    task automatic cmd(input logic [31:0] c, input logic [31:0] e);
        wr(`AEO_REG_CMD, c);
        rd(`AEO_REG_OFFS);
        chk("offset", e, rv);
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'h1;
        rd(`AEO_REG_ULIM);
        chk("ulim", 32'hFFFFFFFF, rv);
        rd(8'hFC);
        chk("unmapped", 32'h0, rv);
        tgt <= 32'h100;
        wr(`AEO_REG_PSET, 32'h500);
        wr(`AEO_REG_CTRL, 32'hD);
        repeat (8) @(posedge ref_clk);
        wr(`AEO_REG_CMD, 32'h2);
        rd(`AEO_REG_PPOS);
        chk("preset pos", 32'h500, rv);
        cmd(32'h4, 32'h400);
        wait_save(32'h400, 3'h0);
        chk("masked irq", 32'h0, {31'h0, irq});
        wr(`AEO_REG_MASK, 32'hF);
        repeat (2) @(posedge ref_clk);
        chk("irq", 32'h1, {31'h0, irq});
        rd(`AEO_REG_IRQ);
        chk("events", 32'h3, rv);
        repeat (2) @(posedge ref_clk);
        chk("irq clear", 32'h0, {31'h0, irq});
        wr(`AEO_REG_OFFS, 32'h0);
        rd(`AEO_REG_OFFS);
        chk("ro offset", 32'h400, rv);
        tgt <= 32'h2000;
        repeat (8) @(posedge ref_clk);
        wr(`AEO_REG_CMD, 32'h1);
        rd(`AEO_REG_PPOS);
        chk("lock pos", 32'h2400, rv);
        rd(`AEO_REG_STAT);
        chk("stat", 32'h3, rv & 32'h3);
        wr(`AEO_REG_CTRL, 32'h5);
        cmd(32'h4, 32'h400);
        wait_save(32'h400, 3'h1);
        wr(`AEO_REG_CTRL, 32'hD);
        wr(`AEO_REG_PSET, 32'h0);
        tgt <= 32'h1234;
        repeat (8) @(posedge ref_clk);
        wr(`AEO_REG_CMD, 32'h2);
        cmd(32'h4, 32'hFFFFEDCC);
        wait_save(32'hFFFFEDCC, 3'h2);
        rd(`AEO_REG_PPOS);
        chk("zero pos", 32'h0, rv);
        wr(`AEO_REG_CTRL, 32'h1);
        wr(`AEO_REG_CMD, 32'h8);
        wait_save(32'hFFFFEDCC, 3'h3);
        wr(`AEO_REG_CTRL, 32'h7);
        saves = 0;
        // Five steps up then four down: travel counts in both directions
        for (int k = 0; k < 9; k++) begin
            tgt <= (k < 5) ? tgt + 32'h10000000 : tgt - 32'h10000000;
            repeat (40) @(posedge ref_clk);
        end
        chk("pulse saves", 32'h2, saves);
        saves = 0;
        // Jump from the low to the top quadrant is one full-range wrap
        tgt <= 32'hF0001234;
        wait_save(32'hFFFFEDCC, 3'h6);
        rd(`AEO_REG_IRQ);
        chk("wrap event", 32'h8, rv & 32'h8);
        save_pending_nv <= 1'h1;
        reset_n <= 1'h0;
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'h1;
        repeat (6) @(posedge ref_clk);
        chk("mem err", 32'h2, {28'h0, unit_err});
        rd(`AEO_REG_IRQ);
        chk("err event", 32'h4, rv & 32'h4);
        save_pending_nv <= 1'h0;
        wr(`AEO_REG_CMD, 32'h4);
        repeat (4) @(posedge ref_clk);
        chk("err clear", 32'h0, {28'h0, unit_err});
        give_verdict();
    end
endmodule
bind aeo_origin aeo_origin_monitor mon (.ref_clk, .reset_n, .reg_rd,
    .reg_rdata, .flash_wr, .flash_slot, .flash_data, .flash_done,
    .save_pending_nv, .save_pending_set, .unit_err);

// [aeo_drive_model.sv]
`timescale 1ns/1ps
module aeo_drive_model #(
    parameter int DONE_DLY = 5
) (
    // Clock
    input logic ref_clk,
    // Where the motor sits
    input logic [31:0] tgt_pos,
    // Feedback and flash answer
    output logic [31:0] fb_pos,
    output logic fb_valid,
    input logic flash_wr,
    output logic flash_done
);
    int cnt = 0;
    int dly = 0;
    initial begin
        fb_pos = 32'h0;
        fb_valid = 1'h0;
        flash_done = 1'h0;
    end
    // Stands for a drive whose encoder setup and power cycle are done,
    // so its clear error is gone and positions are trustworthy.
    // Inverse between samples catches a design that ignores fb_valid
    always @(posedge ref_clk) begin
        cnt <= cnt + 1;
        fb_valid <= (cnt % 4 == 0);
        fb_pos <= (cnt % 4 == 0) ? tgt_pos : ~tgt_pos;
    end
    // Flash finishes a few cycles after each save, done held 4 cycles
    always @(posedge ref_clk) begin
        if (flash_wr)
            dly <= 1;
        else if (dly != 0)
            dly <= (dly == DONE_DLY + 4) ? 0 : dly + 1;
        flash_done <= (dly > DONE_DLY);
    end
endmodule

// [aeo_map.vh]
`ifndef AEO_MAP_VH
`define AEO_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AEO_REG_CTRL 8'h00
`define AEO_REG_ULIM 8'h04
`define AEO_REG_PSET 8'h08
`define AEO_REG_CMD 8'h0C
`define AEO_REG_OFFS 8'h10
`define AEO_REG_PPOS 8'h14
`define AEO_REG_STAT 8'h18
`define AEO_REG_IRQ 8'h1C
`define AEO_REG_MASK 8'h20
`define AEO_REG_SLOT 8'h24
// ----------------------------------------
// Field positions
// ----------------------------------------
`define AEO_CTRL_ABS 0
`define AEO_CTRL_ROT 1
`define AEO_CTRL_AUTO 2
`define AEO_CTRL_PRESET 3
`define AEO_CMD_LOCK 0
`define AEO_CMD_SEARCH 1
`define AEO_CMD_DONE 2
`define AEO_CMD_SAVE 3
`define AEO_ST_DEFINED 0
`define AEO_ST_LOCKED 1
`define AEO_ST_BUSY 2
`define AEO_ST_MEMERR 3
`define AEO_EV_UPD 0
`define AEO_EV_SAVED 1
`define AEO_EV_MEMERR 2
`define AEO_EV_WRAP 3
// ----------------------------------------
// Values and counts
// ----------------------------------------
`define AEO_MEMERR_CODE 4'h2
`define AEO_SAVE_PULSES 32'h40000000
`define AEO_NSLOT 8
`define AEO_SLOT_W 3
`define AEO_ULIM_RST 32'hFFFFFFFF
`endif

// [aeo_origin.v]
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "aeo_map.vh"
module aeo_origin (
    // Clock and reset
    input wire ref_clk,
    input wire reset_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // Encoder feedback from the drive
    input wire [31:0] fb_pos,
    input wire fb_valid,
    // Flash save port
    output reg flash_wr,
    output reg [2:0] flash_slot,
    output reg [31:0] flash_data,
    input wire flash_done,
    // Pending flag kept in nonvolatile memory, read at start
    input wire save_pending_nv,
    output reg save_pending_set,
    // Interrupt and memory error
    output reg irq,
    output reg [3:0] unit_err
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [3:0] ctrl_q;
    reg [31:0] ulim_q;
    reg [31:0] pset_q;
    reg [31:0] offs_q;
    reg [31:0] ppos_q;
    reg [31:0] fb_last_q;
    reg [31:0] travel_q;
    reg [3:0] irq_q;
    reg [3:0] mask_q;
    reg defined_q;
    reg locked_q;
    reg busy_q;
    reg memerr_q;
    reg started_q;
    reg [2:0] slot_q;
    reg nv_s1_q;
    reg nv_s2_q;
    reg fd_s1_q;
    reg fd_s2_q;
    reg fd_prev_q;
    reg [31:0] rdata_d;
    reg [3:0] ev_d;
    reg [31:0] offs_d;
    reg upd_d;

    wire cmd_wr = reg_wr && (reg_addr == `AEO_REG_CMD);
    wire abs_en = ctrl_q[`AEO_CTRL_ABS];
    wire rot_en = ctrl_q[`AEO_CTRL_ROT];
    wire auto_en = ctrl_q[`AEO_CTRL_AUTO];
    wire preset_md = ctrl_q[`AEO_CTRL_PRESET];
    wire do_lock = cmd_wr && reg_wdata[`AEO_CMD_LOCK];
    wire do_search = cmd_wr && reg_wdata[`AEO_CMD_SEARCH];
    wire do_done = cmd_wr && reg_wdata[`AEO_CMD_DONE];
    wire do_save = cmd_wr && reg_wdata[`AEO_CMD_SAVE];
    // Between samples fb_pos carries no meaning, so hold the last sample
    wire [31:0] fb_now = fb_valid ? fb_pos : fb_last_q;
    wire [31:0] delta = fb_pos - fb_last_q;
    wire [31:0] step = delta[31] ? (~delta + 32'h00000001) : delta;
    // Wrap through the full 32-bit range: top bit flips between extremes
    wire wrap = fb_valid && (fb_last_q[31:30] != fb_pos[31:30]) &&
        (fb_last_q[31] ^ fb_last_q[30]) == 1'b0 &&
        (fb_pos[31] ^ fb_pos[30]) == 1'b0 &&
        (fb_last_q[31] != fb_pos[31]);
    wire fdone = fd_s2_q && !fd_prev_q;
    wire save_req;
    wire [31:0] ppos_nx;

    // Ring position in 0..ulim
    function [31:0] ring;
        input [31:0] v;
        input [31:0] lim;
        begin
            if (v > lim) begin
                ring = v - lim - 32'h00000001;
            end else begin
                ring = v;
            end
        end
    endfunction

    // Position after the current sample, ring or linear
    assign ppos_nx = rot_en ? ring(ppos_q + delta, ulim_q) :
        ppos_q + delta;

    // ----------------------------------------
    // Offset and present position
    // ----------------------------------------
    always @* begin
        offs_d = offs_q;
        upd_d = 1'b0;
        if (abs_en && do_done) begin
            // Preset mode: origin position becomes the preset value
            offs_d = (preset_md ? pset_q : ppos_q) - fb_now;
            upd_d = 1'b1;
        end else if (abs_en && rot_en && wrap && defined_q) begin
            offs_d = ppos_nx - fb_pos;
            upd_d = 1'b1;
        end
    end

    assign save_req = (upd_d && auto_en) || do_save ||
        (rot_en && abs_en && fb_valid &&
        travel_q + step >= `AEO_SAVE_PULSES);

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            ctrl_q <= 4'h0;
            ulim_q <= `AEO_ULIM_RST;
            pset_q <= 32'h00000000;
            offs_q <= 32'h00000000;
            ppos_q <= 32'h00000000;
            fb_last_q <= 32'h00000000;
            travel_q <= 32'h00000000;
            defined_q <= 1'b0;
            locked_q <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `AEO_REG_CTRL) begin
                ctrl_q <= reg_wdata[3:0];
            end
            if (reg_wr && reg_addr == `AEO_REG_ULIM) begin
                ulim_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == `AEO_REG_PSET) begin
                pset_q <= reg_wdata;
            end
            offs_q <= offs_d;
            if (fb_valid) begin
                fb_last_q <= fb_pos;
                if (save_req) begin
                    travel_q <= 32'h00000000;
                end else if (rot_en && abs_en) begin
                    travel_q <= travel_q + step;
                end
            end
            if (do_lock) begin
                locked_q <= 1'b1;
                if (abs_en) begin
                    // Offset restores position without a new search
                    ppos_q <= ring(fb_now + offs_q, ulim_q);
                    defined_q <= !memerr_q;
                end
            end else if (do_search && preset_md) begin
                ppos_q <= pset_q;
            end else if (do_done) begin
                ppos_q <= preset_md ? pset_q : ppos_q;
                defined_q <= 1'b1;
            end else if (fb_valid && locked_q) begin
                ppos_q <= ppos_nx;
            end
        end
    end

    // ----------------------------------------
    // Flash save with slot rotation
    // ----------------------------------------
    // Pending flag is set with the write pulse and cleared after done, so a
    // power loss mid-save leaves it set for the next start.
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
            slot_q <= 3'h0;
            flash_wr <= 1'b0;
            flash_slot <= 3'h0;
            flash_data <= 32'h00000000;
            save_pending_set <= 1'b0;
            nv_s1_q <= 1'b0;
            nv_s2_q <= 1'b0;
            fd_s1_q <= 1'b0;
            fd_s2_q <= 1'b0;
            fd_prev_q <= 1'b0;
            started_q <= 1'b0;
            memerr_q <= 1'b0;
            unit_err <= 4'h0;
        end else begin
            nv_s1_q <= save_pending_nv;
            nv_s2_q <= nv_s1_q;
            fd_s1_q <= flash_done;
            fd_s2_q <= fd_s1_q;
            fd_prev_q <= fd_s2_q;
            started_q <= 1'b1;
            if (started_q && !memerr_q && nv_s2_q && !busy_q) begin
                memerr_q <= 1'b1;
                unit_err <= `AEO_MEMERR_CODE;
            end else if (do_done && memerr_q) begin
                // Fresh search recomputes the offset
                memerr_q <= 1'b0;
                unit_err <= 4'h0;
            end
            flash_wr <= 1'b0;
            if (save_req && !busy_q) begin
                busy_q <= 1'b1;
                flash_wr <= 1'b1;
                flash_slot <= slot_q;
                flash_data <= offs_d;
                save_pending_set <= 1'b1;
                slot_q <= slot_q + 3'h1;
            end else if (busy_q && fdone) begin
                busy_q <= 1'b0;
                save_pending_set <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Interrupts and read port
    // ----------------------------------------
    always @* begin
        ev_d = 4'h0;
        ev_d[`AEO_EV_UPD] = upd_d;
        ev_d[`AEO_EV_SAVED] = busy_q && fdone;
        ev_d[`AEO_EV_MEMERR] = started_q && !memerr_q && nv_s2_q && !busy_q;
        ev_d[`AEO_EV_WRAP] = wrap && rot_en;
        case (reg_addr)
            `AEO_REG_CTRL: rdata_d = {28'h0, ctrl_q};
            `AEO_REG_ULIM: rdata_d = ulim_q;
            `AEO_REG_PSET: rdata_d = pset_q;
            `AEO_REG_OFFS: rdata_d = offs_q;
            `AEO_REG_PPOS: rdata_d = ppos_q;
            `AEO_REG_STAT: rdata_d = {28'h0, memerr_q, busy_q, locked_q,
                defined_q};
            `AEO_REG_IRQ: rdata_d = {28'h0, irq_q};
            `AEO_REG_MASK: rdata_d = {28'h0, mask_q};
            `AEO_REG_SLOT: rdata_d = {29'h0, slot_q};
            default: rdata_d = 32'h00000000;
        endcase
    end

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            irq_q <= 4'h0;
            mask_q <= 4'h0;
            irq <= 1'b0;
            reg_rdata <= 32'h00000000;
        end else begin
            // New events win over the read clear
            if (reg_rd && reg_addr == `AEO_REG_IRQ) begin
                irq_q <= ev_d;
            end else begin
                irq_q <= irq_q | ev_d;
            end
            if (reg_wr && reg_addr == `AEO_REG_MASK) begin
                mask_q <= reg_wdata[3:0];
            end
            irq <= |(irq_q & mask_q);
            reg_rdata <= reg_rd ? rdata_d : 32'h00000000;
        end
    end

endmodule

// [aeo_origin_monitor.sv]
`timescale 1ns/1ps
module aeo_origin_monitor (
    // Clock and reset
    input logic ref_clk,
    input logic reset_n,
    // Watched ports
    input logic reg_rd,
    input logic [31:0] reg_rdata,
    input logic flash_wr,
    input logic [2:0] flash_slot,
    input logic [31:0] flash_data,
    input logic flash_done,
    input logic save_pending_nv,
    input logic save_pending_set,
    input logic [3:0] unit_err
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic [2:0] slot_q;
    logic seen_q;
    // Slot of the last save, so the next one can be judged
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            seen_q <= 1'h0;
            slot_q <= 3'h0;
        end else if (flash_wr) begin
            seen_q <= 1'h1;
            slot_q <= flash_slot;
        end
    end
    sequence s_save_end;
        save_pending_set && $rose(flash_done);
    endsequence
    sequence s_restart_dirty;
        $rose(reset_n) && save_pending_nv;
    endsequence
    AST_WR_PULSE: assert property (flash_wr |=> !flash_wr)
        else $error("flash write longer than one cycle");
    AST_DATA_HOLD: assert property
        (!flash_wr |-> $stable(flash_data) && $stable(flash_slot))
        else $error("flash data moved without a save");
    AST_SLOT_NEXT: assert property
        (flash_wr && seen_q |-> flash_slot == slot_q + 3'h1)
        else $error("save did not move to next slot");
    AST_PEND_WR: assert property (flash_wr |-> save_pending_set)
        else $error("save started without pending flag");
    AST_PEND_RISE: assert property ($rose(save_pending_set) |-> flash_wr)
        else $error("pending flag rose without a save");
    AST_SAVE_END: assert property (s_save_end |-> ##[1:6] !save_pending_set)
        else $error("pending flag stuck after flash done");
    AST_ERR_CODE: assert property (unit_err != 4'h0 |-> unit_err == 4'h2)
        else $error("wrong memory error code");
    AST_ERR_START: assert property
        (s_restart_dirty |-> ##[1:4] unit_err == 4'h2)
        else $error("interrupted save not reported");
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data without a read");
endmodule
